/* common/esm_pkg.sv */
// shared constants and carriers for the ethernet status and media control block
package esm_pkg;
    // register byte addresses
    localparam logic [3:0]  ADDR_CTRL      = 4'h0;
    localparam logic [3:0]  ADDR_STAT      = 4'h4;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    // control bit positions
    localparam int CB_RX_DATA_EN   = 27;
    localparam int CB_RX_HALF_EN   = 26;
    localparam int CB_RX_PKT_EN    = 25;
    localparam int CB_TX_SPACE_EN  = 19;
    localparam int CB_TX_HALF_EN   = 18;
    localparam int CB_TX_DONE_EN   = 17;
    localparam int CB_MODE_HI      = 15;
    localparam int CB_MODE_LO      = 14;
    localparam int CB_POWER_DOWN   = 7;
    localparam int CB_PORT_HI      = 6;
    localparam int CB_PORT_LO      = 5;
    localparam int CB_LINK_PULSE   = 4;
    localparam int CB_LOOPBACK     = 3;
    localparam int CB_CABLE        = 2;
    // status bit positions
    localparam int SB_BYTES_HI     = 29;
    localparam int SB_BYTES_LO     = 28;
    localparam int SB_RX_DATA      = 27;
    localparam int SB_RX_HALF      = 26;
    localparam int SB_RX_PKT       = 25;
    localparam int SB_RX_DISCARD   = 24;
    localparam int SB_TX_SPACE     = 19;
    localparam int SB_TX_HALF      = 18;
    localparam int SB_TX_DONE      = 17;
    localparam int SB_TX_EMPTY     = 16;
    // fifo thresholds in bytes
    localparam int RX_HALF_BYTES   = 1024;
    localparam int TX_HALF_BYTES   = 64;
    // interface mode encodings
    typedef enum logic [1:0] {
        ESM_MODE_MII   = 2'h0,
        ESM_MODE_RSVD  = 2'h1,
        ESM_MODE_ENDA  = 2'h2,
        ESM_MODE_ENDB  = 2'h3
    } esm_mode_t;
    // fifo side state reported into the block
    typedef struct packed {
        logic        rx_word_avail;
        logic [1:0]  rx_word_byte_count;
        logic [11:0] rx_level_bytes;
        logic        rx_packet_arrived;
        logic        tx_word_space;
        logic [11:0] tx_level_bytes;
        logic        tx_packet_finished;
    } esm_fifo_t;
    // repurposed pin outputs toward the phy
    typedef struct packed {
        logic txd1_o;
        logic txd1_oe;
        logic txd2_o;
        logic txd3_o;
        logic txer_o;
        logic mdc_o;
        logic mdio_o;
        logic mdio_oe;
    } esm_pins_t;
endpackage

/* hw/esm_status_media.sv */
// ethernet general status flags, control register and encoder_decoder_phy media pin mapping
`timescale 1ns/100ps

// What this block does
// - media control bits reach phy pins only in encoder_decoder_phy modes
// - bit 7 drives txd1 inverted, open drain in first variant
// - bits 6:5 drive txd2 and txd3 uninverted as port select
// - bit 4 drives txer uninverted as link pulse control
// - bit 3 drives mdc inverted as phy loopback control
// - bit 2 drives mdio uninverted as cable type select
// - status bits 29:28 give valid bytes of next receive word
// - bit 27 high while receive data readable, interrupt when enabled
// - receive data ready held low while packet ready is set
// - bit 26 high while receive fifo holds over 1024 bytes and packet ready is clear
// - bit 25 set when a new received packet is available
// - writing one to bit 25 clears packet ready, releasing rx flags
// - writing one to bit 24 clears packet ready and discards packet
// - bit 19 high while transmit fifo can accept a word
// - transmit space flag held low while transmit done is set
// - bit 18 high while transmit fifo holds under 64 bytes and transmit done is clear
// - bit 17 set when packet transmission completes
// - writing one to bit 17 clears done, releasing tx flags
// - bit 16 high while transmit fifo is empty
// - bits 15:0 sample phy pins only in encoder_decoder_phy modes
// - mode field 00 mii, 01 reserved, 10 and 11 encoder_decoder_phy variants
module esm_status_media (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // fifo side
    input  wire esm_pkg::esm_fifo_t fifo_i,
    output logic                   rx_discard_pulse,
    // phy pins
    input  wire logic [4:0]        phy_status_pins,
    input  wire esm_pkg::esm_pins_t mii_pins_i,
    output esm_pkg::esm_pins_t     pins_o,
    // interrupt
    output logic                   eth_irq
);
    logic [31:0] ctrl_r;
    logic        rx_pkt_r;
    logic        tx_done_r;
    logic        ack_r;
    logic [31:0] stat_w;
    logic [31:0] wmask_w;
    logic [31:0] ctrl_nxt;
    logic [31:0] rdata_w;
    logic        is_encoder_decoder_phy;
    logic        is_vara;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        wr_stat;
    logic        clr_rx;
    logic        skip_rx;
    logic        clr_tx;
    logic        rx_data_w;
    logic        rx_half_w;
    logic        tx_space_w;
    logic        tx_half_w;
    logic        tx_empty_w;
    logic [15:0] media_w;
    logic        irq_w;
    esm_pkg::esm_mode_t mode_w;
    esm_pkg::esm_pins_t pins_w;

    // byte lane mask
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask_w[g*8 +: 8] = {8{avs_byteenable[g]}};
        end
    endgenerate

    // address decode, one wait cycle per access
    assign hit_ctrl = (avs_address == esm_pkg::ADDR_CTRL);
    assign hit_stat = (avs_address == esm_pkg::ADDR_STAT);
    assign wr_stat  = avs_write && hit_stat && ack_r && clk_en;
    assign ctrl_nxt = (ctrl_r & ~wmask_w) | (avs_writedata & wmask_w);

    // mode decode
    assign mode_w   = esm_pkg::esm_mode_t'(ctrl_r[esm_pkg::CB_MODE_HI:esm_pkg::CB_MODE_LO]);
    assign is_encoder_decoder_phy = (mode_w == esm_pkg::ESM_MODE_ENDA) ||
                      (mode_w == esm_pkg::ESM_MODE_ENDB);
    assign is_vara  = (mode_w == esm_pkg::ESM_MODE_ENDA);

    // write-one clears; zero leaves state alone
    assign clr_rx  = wr_stat && avs_byteenable[3]
                     && avs_writedata[esm_pkg::SB_RX_PKT];
    assign skip_rx = wr_stat && avs_byteenable[3]
                     && avs_writedata[esm_pkg::SB_RX_DISCARD];
    assign clr_tx  = wr_stat && avs_byteenable[2]
                     && avs_writedata[esm_pkg::SB_TX_DONE];

    // level flags, all but tx empty gated by sticky flags
    assign rx_data_w  = fifo_i.rx_word_avail && !rx_pkt_r;
    assign rx_half_w  = (int'(fifo_i.rx_level_bytes) > esm_pkg::RX_HALF_BYTES)
                        && !rx_pkt_r;
    assign tx_space_w = fifo_i.tx_word_space && !tx_done_r;
    assign tx_half_w  = (int'(fifo_i.tx_level_bytes) < esm_pkg::TX_HALF_BYTES)
                        && !tx_done_r;
    assign tx_empty_w = (fifo_i.tx_level_bytes == 12'h000);

    // media status, sampled pins only in encoder_decoder_phy modes
    assign media_w = is_encoder_decoder_phy ? {phy_status_pins[4], 1'b0, phy_status_pins[3],
                                 phy_status_pins[2], phy_status_pins[1],
                                 phy_status_pins[0], 10'h000}
                              : 16'h0000;

    always_comb begin
        stat_w = 32'h0000_0000;
        stat_w[esm_pkg::SB_BYTES_HI:esm_pkg::SB_BYTES_LO] = fifo_i.rx_word_byte_count;
        stat_w[esm_pkg::SB_RX_DATA]  = rx_data_w;
        stat_w[esm_pkg::SB_RX_HALF]  = rx_half_w;
        stat_w[esm_pkg::SB_RX_PKT]   = rx_pkt_r;
        stat_w[esm_pkg::SB_TX_SPACE] = tx_space_w;
        stat_w[esm_pkg::SB_TX_HALF]  = tx_half_w;
        stat_w[esm_pkg::SB_TX_DONE]  = tx_done_r;
        stat_w[esm_pkg::SB_TX_EMPTY] = tx_empty_w;
        stat_w[15:0] = media_w;
    end

    assign irq_w = (rx_data_w  && ctrl_r[esm_pkg::CB_RX_DATA_EN])  ||
                   (rx_half_w  && ctrl_r[esm_pkg::CB_RX_HALF_EN])  ||
                   (rx_pkt_r   && ctrl_r[esm_pkg::CB_RX_PKT_EN])   ||
                   (tx_space_w && ctrl_r[esm_pkg::CB_TX_SPACE_EN]) ||
                   (tx_half_w  && ctrl_r[esm_pkg::CB_TX_HALF_EN])  ||
                   (tx_done_r  && ctrl_r[esm_pkg::CB_TX_DONE_EN]);

    // pin mapping; mii function passes through otherwise
    always_comb begin
        pins_w = mii_pins_i;
        if (is_encoder_decoder_phy) begin
            pins_w.txd1_o  = is_vara ? 1'b0 : !ctrl_r[esm_pkg::CB_POWER_DOWN];
            pins_w.txd1_oe = is_vara ? ctrl_r[esm_pkg::CB_POWER_DOWN] : 1'b1;
            pins_w.txd2_o  = ctrl_r[esm_pkg::CB_PORT_HI];
            pins_w.txd3_o  = ctrl_r[esm_pkg::CB_PORT_LO];
            pins_w.txer_o  = ctrl_r[esm_pkg::CB_LINK_PULSE];
            pins_w.mdc_o   = !ctrl_r[esm_pkg::CB_LOOPBACK];
            pins_w.mdio_o  = ctrl_r[esm_pkg::CB_CABLE];
            pins_w.mdio_oe = 1'b1;
        end
    end

    // bus handshake and control register
    // waitrequest idles high and drops only for the cycle an access is taken
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
            ctrl_r          <= esm_pkg::CTRL_RESET;
        end else if (clk_en) begin
            ack_r           <= (avs_read || avs_write) && !ack_r;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
            if (avs_write && hit_ctrl && ack_r) begin
                ctrl_r <= ctrl_nxt;
            end
        end
    end

    // read select, unmapped addresses read zero
    assign rdata_w = hit_ctrl ? ctrl_r : (hit_stat ? stat_w : 32'h0000_0000);

    // read data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            avs_readdata <= rdata_w;
        end
    end

    // sticky flags, a new event wins over a clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_pkt_r  <= 1'b0;
            tx_done_r <= 1'b0;
        end else if (clk_en) begin
            rx_pkt_r  <= fifo_i.rx_packet_arrived || (rx_pkt_r && !clr_rx && !skip_rx);
            tx_done_r <= fifo_i.tx_packet_finished || (tx_done_r && !clr_tx);
        end
    end

    // registered outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_discard_pulse <= 1'b0;
            eth_irq          <= 1'b0;
            pins_o           <= '0;
        end else if (clk_en) begin
            rx_discard_pulse <= skip_rx;
            eth_irq          <= irq_w;
            pins_o           <= pins_w;
        end
    end

    // checks
    property p_rx_gate;
        @(posedge clk) disable iff (sys_rst)
        rx_pkt_r |-> !stat_w[esm_pkg::SB_RX_DATA] && !stat_w[esm_pkg::SB_RX_HALF];
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx ready while packet flag set");

    property p_tx_gate;
        @(posedge clk) disable iff (sys_rst)
        tx_done_r |-> !stat_w[esm_pkg::SB_TX_SPACE];
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx space while done set");

    property p_rx_set;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && fifo_i.rx_packet_arrived) |=> rx_pkt_r;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("packet flag not set");

    property p_tx_set;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && fifo_i.tx_packet_finished) |=> tx_done_r;
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("done flag not set");

    property p_skip;
        @(posedge clk) disable iff (sys_rst)
        (skip_rx && !fifo_i.rx_packet_arrived) |=> !rx_pkt_r && rx_discard_pulse;
    endproperty
    a_skip: assert property (p_skip) else $error("skip did not clear and discard");

    property p_zero_write;
        @(posedge clk) disable iff (sys_rst)
        (wr_stat && !avs_writedata[esm_pkg::SB_TX_DONE] && tx_done_r) |=> tx_done_r;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write cleared");

    property p_mii_pins;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !is_encoder_decoder_phy) |=> pins_o == $past(mii_pins_i);
    endproperty
    a_mii_pins: assert property (p_mii_pins) else $error("pins changed in mii mode");

    property p_loop_pin;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && is_encoder_decoder_phy) |=> pins_o.mdc_o == !$past(ctrl_r[esm_pkg::CB_LOOPBACK]);
    endproperty
    a_loop_pin: assert property (p_loop_pin) else $error("mdc not inverted loopback");

    property p_media_zero;
        @(posedge clk) disable iff (sys_rst)
        !is_encoder_decoder_phy |-> stat_w[15:0] == 16'h0000;
    endproperty
    a_media_zero: assert property (p_media_zero) else $error("media status outside encoder_decoder_phy");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && tx_done_r && ctrl_r[esm_pkg::CB_TX_DONE_EN]) |=> eth_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_pdn_open;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && is_vara) |=>
            !pins_o.txd1_o && (pins_o.txd1_oe == $past(ctrl_r[esm_pkg::CB_POWER_DOWN]));
    endproperty
    a_pdn_open: assert property (p_pdn_open) else $error("open drain power down wrong");

    property p_pdn_push;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && (mode_w == esm_pkg::ESM_MODE_ENDB)) |=>
            pins_o.txd1_oe && (pins_o.txd1_o == !$past(ctrl_r[esm_pkg::CB_POWER_DOWN]));
    endproperty
    a_pdn_push: assert property (p_pdn_push) else $error("push pull power down wrong");

    property p_port_pins;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && is_encoder_decoder_phy) |=> (pins_o.txd2_o == $past(ctrl_r[esm_pkg::CB_PORT_HI])) &&
            (pins_o.txd3_o == $past(ctrl_r[esm_pkg::CB_PORT_LO]));
    endproperty
    a_port_pins: assert property (p_port_pins) else $error("port select pins wrong");

    property p_link_pin;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && is_encoder_decoder_phy) |=> pins_o.txer_o == $past(ctrl_r[esm_pkg::CB_LINK_PULSE]);
    endproperty
    a_link_pin: assert property (p_link_pin) else $error("link pulse pin wrong");

    property p_cable_pin;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && is_encoder_decoder_phy) |=> pins_o.mdio_oe &&
            (pins_o.mdio_o == $past(ctrl_r[esm_pkg::CB_CABLE]));
    endproperty
    a_cable_pin: assert property (p_cable_pin) else $error("cable select pin wrong");

    property p_byte_count;
        @(posedge clk) disable iff (sys_rst)
        stat_w[esm_pkg::SB_BYTES_HI:esm_pkg::SB_BYTES_LO] == fifo_i.rx_word_byte_count;
    endproperty
    a_byte_count: assert property (p_byte_count) else $error("byte count field wrong");

    property p_rx_data;
        @(posedge clk) disable iff (sys_rst)
        (!rx_pkt_r && fifo_i.rx_word_avail) |-> stat_w[esm_pkg::SB_RX_DATA];
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("rx data flag missing");

    property p_rx_half;
        @(posedge clk) disable iff (sys_rst)
        (!rx_pkt_r && (int'(fifo_i.rx_level_bytes) > esm_pkg::RX_HALF_BYTES))
            |-> stat_w[esm_pkg::SB_RX_HALF];
    endproperty
    a_rx_half: assert property (p_rx_half) else $error("rx half flag missing");

    property p_tx_space;
        @(posedge clk) disable iff (sys_rst)
        (!tx_done_r && fifo_i.tx_word_space) |-> stat_w[esm_pkg::SB_TX_SPACE];
    endproperty
    a_tx_space: assert property (p_tx_space) else $error("tx space flag missing");

    property p_tx_half;
        @(posedge clk) disable iff (sys_rst)
        (!tx_done_r && (int'(fifo_i.tx_level_bytes) < esm_pkg::TX_HALF_BYTES))
            |-> stat_w[esm_pkg::SB_TX_HALF];
    endproperty
    a_tx_half: assert property (p_tx_half) else $error("tx half flag missing");

    property p_tx_empty;
        @(posedge clk) disable iff (sys_rst)
        (fifo_i.tx_level_bytes == 12'h000) |-> stat_w[esm_pkg::SB_TX_EMPTY];
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag missing");

    property p_rx_clear;
        @(posedge clk) disable iff (sys_rst)
        (clr_rx && !fifo_i.rx_packet_arrived) |=> !rx_pkt_r;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("packet flag not cleared");

    property p_tx_clear;
        @(posedge clk) disable iff (sys_rst)
        (clr_tx && !fifo_i.tx_packet_finished) |=> !tx_done_r;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("done flag not cleared");
endmodule

/* testbench/esm_phy_model.sv */
// encoder_decoder_phy phy model decoding media pins and driving media status pins
`timescale 1ns/100ps
module esm_phy_model (
    // media pins from the block
    input  wire esm_pkg::esm_pins_t pins,
    // status the phy reports
    input  wire logic [4:0]         stat_i,
    output logic      [4:0]         stat_pins,
    // decoded controls: power down, port, link, loopback, cable
    output logic      [5:0]         media
);
    // pull-ups on released lines
    wire txd1_w = pins.txd1_oe ? pins.txd1_o : 1'b1;
    wire mdio_w = pins.mdio_oe ? pins.mdio_o : 1'b1;
    assign media = {~txd1_w, pins.txd2_o, pins.txd3_o, pins.txer_o, ~pins.mdc_o, mdio_w};
    assign stat_pins = stat_i;
endmodule

/* testbench/tb_esm_status_media.sv */
// self-checking bench for the status flags and media control block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("FAIL %0t %h %h", $time, (a), (b)); end end
module tb_esm_status_media;
    logic               clk     = 1'b0;
    logic               sys_rst = 1'b1;
    logic               ce      = 1'b1;
    logic [3:0]         adr     = 4'h0;
    logic               rd      = 1'b0;
    logic               wr      = 1'b0;
    logic [31:0]        wd      = 32'h0;
    logic [31:0]        q;
    logic [31:0]        rdd;
    logic               wreq;
    logic               disc;
    logic               irq;
    esm_pkg::esm_fifo_t ff      = '0;
    esm_pkg::esm_pins_t mii     = 8'hA5;
    esm_pkg::esm_pins_t po;
    logic [4:0]         ps      = 5'h00;
    logic [4:0]         psp;
    logic [5:0]         media;
    logic [1:0]         m;
    logic [7:0]         c;
    logic [4:0]         pv;
    logic [15:0]        es;
    int                 error_cnt = 0;
    int                 n_tests = 0;
    int                 nd = 0;
    int                 en [6] = '{27, 26, 25, 19, 18, 17};
    // mode, control byte, phy status, expected low status
    logic [30:0]        rows [6] = '{
        {2'h2, 8'hFC, 5'h1F, 16'hBC00}, {2'h2, 8'h00, 5'h00, 16'h0000},
        {2'h3, 8'hA8, 5'h15, 16'h9400}, {2'h3, 8'h54, 5'h0A, 16'h2800},
        {2'h0, 8'hFC, 5'h1F, 16'h0000}, {2'h1, 8'hFC, 5'h1F, 16'h0000}};

    always #10 clk = ~clk;

    esm_status_media uut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
        .avs_readdata(rdd), .avs_waitrequest(wreq), .fifo_i(ff), .rx_discard_pulse(disc),
        .phy_status_pins(psp), .mii_pins_i(mii), .pins_o(po), .eth_irq(irq));
    esm_phy_model phy (.pins(po), .stat_i(ps), .stat_pins(psp), .media(media));

    always @(posedge clk) begin
        if (disc === 1'b1) nd <= nd + 1;
    end

    task finish_test;
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            n++;
            if (n > 20) begin
                error_cnt++;
                finish_test;
            end
            @(posedge clk);
        end
        q = rdd;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task pulse(input logic rx);
        @(posedge clk);
        if (rx) ff.rx_packet_arrived <= 1'b1;
        else ff.tx_packet_finished <= 1'b1;
        @(posedge clk);
        ff.rx_packet_arrived <= 1'b0;
        ff.tx_packet_finished <= 1'b0;
        bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
    endtask

    // expected status word in mii mode
    function automatic logic [31:0] est(input logic p, input logic d);
        logic [31:0] s;
        s = 32'h0;
        s[29:28] = ff.rx_word_byte_count;
        s[27] = ff.rx_word_avail & ~p;
        s[26] = (ff.rx_level_bytes > esm_pkg::RX_HALF_BYTES) & ~p;
        s[25] = p;
        s[19] = ff.tx_word_space & ~d;
        s[18] = (ff.tx_level_bytes < esm_pkg::TX_HALF_BYTES) & ~d;
        s[17] = d;
        s[16] = (ff.tx_level_bytes == 12'h000);
        return s;
    endfunction

    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end

    initial begin
        repeat (8) @(posedge clk);
        `CHK(po, 8'h00)
        `CHK(irq, 1'b0)
        `CHK(rdd, 32'h0)
        `CHK(disc, 1'b0)
        sys_rst <= 1'b0;
        ff.rx_word_avail <= 1'b1;
        ff.tx_word_space <= 1'b1;
        bus(1'b0, esm_pkg::ADDR_CTRL, 32'h0);
        `CHK(q, esm_pkg::CTRL_RESET)
        foreach (rows[i]) begin
            {m, c, pv, es} = rows[i];
            ps <= pv;
            bus(1'b1, esm_pkg::ADDR_CTRL, {16'h0, m, 6'h0, c});
            bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
            `CHK(q[15:0], es)
            if (m[1]) begin
                `CHK(media, c[7:2])
                `CHK(po.txd1_oe, m[0] | c[7])
            end else `CHK(po, mii)
        end
        bus(1'b1, esm_pkg::ADDR_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ff.rx_word_byte_count <= i[1:0];
            ff.rx_level_bytes <= 12'd1023 + i[11:0];
            ff.tx_level_bytes <= (i == 0) ? 12'd0 : 12'd62 + i[11:0];
            bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
            `CHK(q, est(1'b0, 1'b0))
        end
        ff.tx_level_bytes <= 12'd10;
        foreach (en[i]) begin
            bus(1'b1, esm_pkg::ADDR_CTRL, 32'h1 << en[i]);
            repeat (2) @(posedge clk);
            `CHK(irq, est(1'b0, 1'b0) >> en[i] & 32'h1)
        end
        bus(1'b1, esm_pkg::ADDR_CTRL, 32'h0200_0000);
        pulse(1'b1);
        `CHK(q, est(1'b1, 1'b0))
        `CHK(irq, 1'b1)
        bus(1'b1, esm_pkg::ADDR_STAT, 32'hFCFD_FFFF);
        bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
        `CHK(q, est(1'b1, 1'b0))
        bus(1'b1, esm_pkg::ADDR_STAT, 32'h0200_0000);
        bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
        `CHK(q, est(1'b0, 1'b0))
        `CHK(irq, 1'b0)
        `CHK(nd, 0)
        pulse(1'b1);
        bus(1'b1, esm_pkg::ADDR_STAT, 32'h0100_0000);
        bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
        `CHK(q, est(1'b0, 1'b0))
        `CHK(nd, 1)
        bus(1'b1, esm_pkg::ADDR_CTRL, 32'h0002_0000);
        pulse(1'b0);
        `CHK(q, est(1'b0, 1'b1))
        `CHK(irq, 1'b1)
        bus(1'b1, esm_pkg::ADDR_STAT, 32'h0002_0000);
        bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
        `CHK(q, est(1'b0, 1'b0))
        ce <= 1'b0;
        ff.tx_packet_finished <= 1'b1;
        @(posedge clk);
        ff.tx_packet_finished <= 1'b0;
        ce <= 1'b1;
        bus(1'b0, esm_pkg::ADDR_STAT, 32'h0);
        `CHK(q, est(1'b0, 1'b0))
        `CHK(irq, 1'b0)
        bus(1'b1, 4'h8, 32'hFFFF_FFFF);
        bus(1'b0, 4'h8, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b0, esm_pkg::ADDR_CTRL, 32'h0);
        `CHK(q, 32'h0002_0000)
        sys_rst <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        `CHK(po, 8'h00)
        `CHK(irq, 1'b0)
        `CHK(rdd, 32'h0)
        `CHK(disc, 1'b0)
        sys_rst <= 1'b0;
        bus(1'b0, esm_pkg::ADDR_CTRL, 32'h0);
        `CHK(q, esm_pkg::CTRL_RESET)
        finish_test;
    end
endmodule
